// ===== rtl/lic_decoder.sv
// indirect command decoder of a graphics display controller
// assumes host strobes are one clock wide and synchronous to CLK_I
`default_nettype none
module lic_decoder #(
	parameter int MEM_AW = 8
) (
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        CS_N_I,
	input  wire logic        CMD_DATA_SEL_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	input  wire logic [7:0]  DATA_I,
	output logic      [7:0]  DATA_O,
	output logic             DATA_OE_O,
	output logic             RD_VALID_O,
	input  wire logic [15:0] SCAN_ADDR_I,
	output logic      [7:0]  SCAN_DATA_O,
	output logic             GLYPH_SOURCE_SEL_O,
	output logic             GLYPH_LINES_SEL_O,
	output logic             TWO_PANEL_O,
	output logic             TOP_LINE_COMP_O,
	output logic      [3:0]  CELL_WIDTH_O,
	output logic             AC_DRIVE_SEL_O,
	output logic      [3:0]  CELL_HEIGHT_O,
	output logic      [7:0]  LINE_ADDR_COUNT_O,
	output logic      [7:0]  LINE_TOTAL_COUNT_O,
	output logic      [7:0]  FRAME_LINE_COUNT_O,
	output logic      [15:0] VIRTUAL_WIDTH_O,
	output logic             DISPLAY_EN_O,
	output logic      [1:0]  CURSOR_FLASH_SEL_O,
	output logic      [1:0]  BLOCK1_ATTR_O,
	output logic      [1:0]  BLOCK2_4_ATTR_O,
	output logic      [1:0]  BLOCK3_ATTR_O,
	output logic      [15:0] BLOCK1_START_O,
	output logic      [15:0] BLOCK2_START_O,
	output logic      [15:0] BLOCK3_START_O,
	output logic      [15:0] BLOCK4_START_O,
	output logic      [7:0]  BLOCK1_LINES_O,
	output logic      [7:0]  BLOCK2_LINES_O,
	output logic      [3:0]  CURSOR_WIDTH_O,
	output logic      [3:0]  CURSOR_HEIGHT_O,
	output logic             CURSOR_SHAPE_SEL_O,
	output logic      [1:0]  CURSOR_DIR_O,
	output logic      [1:0]  COMBINE_METHOD_O,
	output logic             BLOCK1_TEXT_SEL_O,
	output logic             BLOCK3_TEXT_SEL_O,
	output logic      [2:0]  PIXEL_SHIFT_O,
	output logic      [15:0] CURSOR_ADDR_O
);
	// first register loaded by each parameter-taking command
	function automatic logic [4:0] cmd_base(input logic [7:0] code);
		case (code)
			lic_pkg::CMD_SYSTEM_SET:    cmd_base = lic_pkg::REG_SYSTEM_CONFIG;
			lic_pkg::CMD_SCROLL:        cmd_base = lic_pkg::REG_BLOCK1_LOW;
			lic_pkg::CMD_PIXEL_SCROLL:  cmd_base = lic_pkg::REG_PIXEL_SHIFT;
			lic_pkg::CMD_LAYER_COMBINE: cmd_base = lic_pkg::REG_LAYER_OVERLAY;
			lic_pkg::CMD_SCREEN_OFF,
			lic_pkg::CMD_SCREEN_ON:     cmd_base = lic_pkg::REG_DISPLAY_ATTR;
			lic_pkg::CMD_CURSOR_LOAD:   cmd_base = lic_pkg::REG_CURSOR_LOW;
			lic_pkg::CMD_CURSOR_SHAPE:  cmd_base = lic_pkg::REG_CURSOR_WIDTH;
			default:                    cmd_base = lic_pkg::REG_SYSTEM_CONFIG;
		endcase
	endfunction

	// number of parameter bytes a command accepts
	function automatic logic [3:0] cmd_count(input logic [7:0] code);
		case (code)
			lic_pkg::CMD_SYSTEM_SET:    cmd_count = lic_pkg::CNT_SYSTEM_SET;
			lic_pkg::CMD_SCROLL:        cmd_count = lic_pkg::CNT_SCROLL;
			lic_pkg::CMD_PIXEL_SCROLL,
			lic_pkg::CMD_LAYER_COMBINE,
			lic_pkg::CMD_SCREEN_OFF,
			lic_pkg::CMD_SCREEN_ON:     cmd_count = lic_pkg::CNT_ONE;
			lic_pkg::CMD_CURSOR_LOAD,
			lic_pkg::CMD_CURSOR_SHAPE:  cmd_count = lic_pkg::CNT_TWO;
			default:                    cmd_count = 4'h0;
		endcase
	endfunction

	// writable bits of each register
	function automatic logic [7:0] reg_mask(input logic [4:0] idx);
		case (idx)
			lic_pkg::REG_SYSTEM_CONFIG: reg_mask = lic_pkg::MASK_SYSTEM_CONFIG;
			lic_pkg::REG_CHAR_WIDTH:    reg_mask = lic_pkg::MASK_CHAR_WIDTH;
			lic_pkg::REG_CHAR_HEIGHT,
			lic_pkg::REG_CURSOR_WIDTH,
			lic_pkg::REG_LAYER_OVERLAY: reg_mask = lic_pkg::MASK_NIBBLE;
			lic_pkg::REG_CURSOR_HEIGHT: reg_mask = lic_pkg::MASK_CURSOR_HEIGHT;
			lic_pkg::REG_PIXEL_SHIFT:   reg_mask = lic_pkg::MASK_PIXEL_SHIFT;
			default:                    reg_mask = lic_pkg::MASK_FULL;
		endcase
	endfunction

	logic [7:0]  regs_q [lic_pkg::REG_COUNT];
	logic [7:0]  regs_d [lic_pkg::REG_COUNT];
	logic [7:0]  cmd_q;
	logic [7:0]  cmd_d;
	logic [3:0]  pcnt_q;
	logic [3:0]  pcnt_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic        wr_take;
	logic        rd_take;
	logic        cmd_take;
	logic        par_take;
	logic        par_load;
	logic        off_cmd;
	logic        on_cmd;
	logic        step_cmd;
	logic        rd_mem;
	logic        rd_cur;
	logic [15:0] cursor;
	logic [15:0] pitch;
	logic [15:0] cursor_next;
	logic        mem_we;
	logic [7:0]  mem_hdata;
	logic [4:0]  pidx;

	// host strobes qualified by the chip select
	assign wr_take = WR_I && !CS_N_I;
	assign rd_take = RD_I && !CS_N_I;

	// write bytes told apart by the select line
	assign cmd_take = wr_take && CMD_DATA_SEL_I;
	assign par_take = wr_take && !CMD_DATA_SEL_I;
	assign par_load = par_take && cmd_q != lic_pkg::CMD_MEMORY_STORE &&
	                  pcnt_q < cmd_count(cmd_q);

	// commands that act at once on the command byte, before any parameter
	assign off_cmd  = cmd_take && DATA_I == lic_pkg::CMD_SCREEN_OFF;
	assign on_cmd   = cmd_take && DATA_I == lic_pkg::CMD_SCREEN_ON;
	assign step_cmd = cmd_take && DATA_I[7:2] == lic_pkg::CMD_CURSOR_STEP;

	// sel-high reads, split by the last command byte
	assign rd_mem = rd_take && CMD_DATA_SEL_I &&
	                cmd_q == lic_pkg::CMD_MEMORY_FETCH;
	assign rd_cur = rd_take && CMD_DATA_SEL_I &&
	                cmd_q == lic_pkg::CMD_CURSOR_FETCH;

	assign cursor = {regs_q[lic_pkg::REG_CURSOR_HIGH],
	                 regs_q[lic_pkg::REG_CURSOR_LOW]};
	assign pitch  = {regs_q[lic_pkg::REG_VWIDTH_HIGH],
	                 regs_q[lic_pkg::REG_VWIDTH_LOW]};
	assign pidx   = cmd_base(cmd_q) + 5'(pcnt_q);

	// one step of the memory cursor
	lic_cursor_step u_step (
		.addr_i  (cursor),
		.dir_i   (regs_q[lic_pkg::REG_CURSOR_DIR][1:0]),
		.pitch_i (pitch),
		.next_o  (cursor_next)
	);

	// memory store writes at the cursor before it moves
	assign mem_we = wr_take && !CMD_DATA_SEL_I &&
	                cmd_q == lic_pkg::CMD_MEMORY_STORE;

	lic_display_mem #(
		.AW (MEM_AW)
	) u_mem (
		.clk_i   (CLK_I),
		.nrst_i  (NRST_I),
		.we_i    (mem_we),
		.waddr_i (cursor[MEM_AW-1:0]),
		.wdata_i (DATA_I),
		.haddr_i (cursor[MEM_AW-1:0]),
		.hdata_o (mem_hdata),
		.saddr_i (SCAN_ADDR_I[MEM_AW-1:0]),
		.sdata_o (SCAN_DATA_O)
	);

	// command and parameter decode, next register values
	always_comb begin
		regs_d   = regs_q;
		cmd_d    = cmd_q;
		pcnt_d   = pcnt_q;
		if (cmd_take) begin
			// a command byte restarts the parameter sequence
			cmd_d  = DATA_I;
			pcnt_d = 4'h0;
			if (off_cmd) begin
				regs_d[lic_pkg::REG_DISPLAY_ENABLE][lic_pkg::BIT_DISPLAY_EN] =
					1'b0;
			end
			if (on_cmd) begin
				regs_d[lic_pkg::REG_DISPLAY_ENABLE][lic_pkg::BIT_DISPLAY_EN] =
					1'b1;
			end
			if (step_cmd) begin
				regs_d[lic_pkg::REG_CURSOR_DIR] = {6'h00, DATA_I[1:0]};
			end
		end else if (par_take) begin
			// a store writes at the cursor, then steps it
			if (cmd_q == lic_pkg::CMD_MEMORY_STORE) begin
				regs_d[lic_pkg::REG_CURSOR_LOW]  = cursor_next[7:0];
				regs_d[lic_pkg::REG_CURSOR_HIGH] = cursor_next[15:8];
			end else if (par_load) begin
				// sequential load
				regs_d[pidx] = DATA_I & reg_mask(pidx);
				pcnt_d       = pcnt_q + 4'h1;
			end
		end
		// a fetch step comes last, so it wins over a store step
		if (rd_mem) begin
			regs_d[lic_pkg::REG_CURSOR_LOW]  = cursor_next[7:0];
			regs_d[lic_pkg::REG_CURSOR_HIGH] = cursor_next[15:8];
		end
		// cursor reads alternate low, high on the shared counter
		if (rd_cur) begin
			pcnt_d = pcnt_q + 4'h1;
		end
	end

	// register state
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			for (int i = 0; i < lic_pkg::REG_COUNT; i++) begin
				regs_q[i] <= lic_pkg::REG_RESET;
			end
			cmd_q    <= 8'h00;
			pcnt_q   <= 4'h0;
		end else begin
			regs_q   <= regs_d;
			cmd_q    <= cmd_d;
			pcnt_q   <= pcnt_d;
		end
	end

	// read answer: byte and valid for the cycle after the strobe
	always_comb begin
		rdata_d  = rdata_q; // holds until the next read
		rvalid_d = rd_take;
		if (rd_mem) begin
			rdata_d = mem_hdata;
		end else if (rd_cur) begin
			rdata_d = pcnt_q[0] ? cursor[15:8] : cursor[7:0];
		end else if (rd_take) begin
			rdata_d = 8'h00; // other reads answer zero
		end
	end

	// read answer registers
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// host read answer, one cycle after the strobe
	assign DATA_O     = rdata_q;
	assign DATA_OE_O  = rvalid_q;
	assign RD_VALID_O = rvalid_q;

	// system configuration fields
	assign GLYPH_SOURCE_SEL_O =
		regs_q[lic_pkg::REG_SYSTEM_CONFIG][lic_pkg::BIT_GLYPH_SOURCE];
	assign GLYPH_LINES_SEL_O  =
		regs_q[lic_pkg::REG_SYSTEM_CONFIG][lic_pkg::BIT_GLYPH_LINES];
	assign TWO_PANEL_O        =
		regs_q[lic_pkg::REG_SYSTEM_CONFIG][lic_pkg::BIT_TWO_PANEL];
	assign TOP_LINE_COMP_O    =
		regs_q[lic_pkg::REG_SYSTEM_CONFIG][lic_pkg::BIT_TOP_LINE];
	assign CELL_WIDTH_O       = regs_q[lic_pkg::REG_CHAR_WIDTH][3:0];
	assign AC_DRIVE_SEL_O     =
		regs_q[lic_pkg::REG_CHAR_WIDTH][lic_pkg::BIT_AC_DRIVE];
	assign CELL_HEIGHT_O      = regs_q[lic_pkg::REG_CHAR_HEIGHT][3:0];
	assign LINE_ADDR_COUNT_O  = regs_q[lic_pkg::REG_LINE_ADDR_CNT];
	assign LINE_TOTAL_COUNT_O = regs_q[lic_pkg::REG_LINE_TOTAL_CNT];
	assign FRAME_LINE_COUNT_O = regs_q[lic_pkg::REG_FRAME_LINE_CNT];
	assign VIRTUAL_WIDTH_O    = pitch;

	// display switch and attributes
	assign DISPLAY_EN_O       =
		regs_q[lic_pkg::REG_DISPLAY_ENABLE][lic_pkg::BIT_DISPLAY_EN];
	assign CURSOR_FLASH_SEL_O = regs_q[lic_pkg::REG_DISPLAY_ATTR][1:0];
	assign BLOCK1_ATTR_O      = regs_q[lic_pkg::REG_DISPLAY_ATTR][3:2];
	assign BLOCK2_4_ATTR_O    = regs_q[lic_pkg::REG_DISPLAY_ATTR][5:4];
	assign BLOCK3_ATTR_O      = regs_q[lic_pkg::REG_DISPLAY_ATTR][7:6];

	// screen block starts and line counts
	assign BLOCK1_START_O = {regs_q[lic_pkg::REG_BLOCK1_HIGH],
	                         regs_q[lic_pkg::REG_BLOCK1_LOW]};
	assign BLOCK2_START_O = {regs_q[lic_pkg::REG_BLOCK2_HIGH],
	                         regs_q[lic_pkg::REG_BLOCK2_LOW]};
	assign BLOCK3_START_O = {regs_q[lic_pkg::REG_BLOCK3_HIGH],
	                         regs_q[lic_pkg::REG_BLOCK3_LOW]};
	assign BLOCK4_START_O = {regs_q[lic_pkg::REG_BLOCK4_HIGH],
	                         regs_q[lic_pkg::REG_BLOCK4_LOW]};
	assign BLOCK1_LINES_O = regs_q[lic_pkg::REG_BLOCK1_LINES];
	assign BLOCK2_LINES_O = regs_q[lic_pkg::REG_BLOCK2_LINES];

	// cursor shape, direction, position
	assign CURSOR_WIDTH_O     = regs_q[lic_pkg::REG_CURSOR_WIDTH][3:0];
	assign CURSOR_HEIGHT_O    = regs_q[lic_pkg::REG_CURSOR_HEIGHT][3:0];
	assign CURSOR_SHAPE_SEL_O =
		regs_q[lic_pkg::REG_CURSOR_HEIGHT][lic_pkg::BIT_SHAPE_SEL];
	assign CURSOR_DIR_O       = regs_q[lic_pkg::REG_CURSOR_DIR][1:0];
	assign CURSOR_ADDR_O      = cursor;

	// layer overlay and pixel scroll
	assign COMBINE_METHOD_O  = regs_q[lic_pkg::REG_LAYER_OVERLAY][1:0];
	assign BLOCK1_TEXT_SEL_O =
		regs_q[lic_pkg::REG_LAYER_OVERLAY][lic_pkg::BIT_BLOCK1_TEXT];
	assign BLOCK3_TEXT_SEL_O =
		regs_q[lic_pkg::REG_LAYER_OVERLAY][lic_pkg::BIT_BLOCK3_TEXT];
	assign PIXEL_SHIFT_O     = regs_q[lic_pkg::REG_PIXEL_SHIFT][2:0];
endmodule
`default_nettype wire

// ===== rtl/lic_pkg.sv
// constants of the indirect command decoder: offsets, masks, codes
// assumes a single clock domain and an 8-bit host data path
`default_nettype none
package lic_pkg;
	// configuration register offsets
	localparam logic [4:0] REG_SYSTEM_CONFIG   = 5'h00;
	localparam logic [4:0] REG_CHAR_WIDTH      = 5'h01;
	localparam logic [4:0] REG_CHAR_HEIGHT     = 5'h02;
	localparam logic [4:0] REG_LINE_ADDR_CNT   = 5'h03;
	localparam logic [4:0] REG_LINE_TOTAL_CNT  = 5'h04;
	localparam logic [4:0] REG_FRAME_LINE_CNT  = 5'h05;
	localparam logic [4:0] REG_VWIDTH_LOW      = 5'h06;
	localparam logic [4:0] REG_VWIDTH_HIGH     = 5'h07;
	localparam logic [4:0] REG_DISPLAY_ENABLE  = 5'h09;
	localparam logic [4:0] REG_DISPLAY_ATTR    = 5'h0a;
	localparam logic [4:0] REG_BLOCK1_LOW      = 5'h0b;
	localparam logic [4:0] REG_BLOCK1_HIGH     = 5'h0c;
	localparam logic [4:0] REG_BLOCK1_LINES    = 5'h0d;
	localparam logic [4:0] REG_BLOCK2_LOW      = 5'h0e;
	localparam logic [4:0] REG_BLOCK2_HIGH     = 5'h0f;
	localparam logic [4:0] REG_BLOCK2_LINES    = 5'h10;
	localparam logic [4:0] REG_BLOCK3_LOW      = 5'h11;
	localparam logic [4:0] REG_BLOCK3_HIGH     = 5'h12;
	localparam logic [4:0] REG_BLOCK4_LOW      = 5'h13;
	localparam logic [4:0] REG_BLOCK4_HIGH     = 5'h14;
	localparam logic [4:0] REG_CURSOR_WIDTH    = 5'h15;
	localparam logic [4:0] REG_CURSOR_HEIGHT   = 5'h16;
	localparam logic [4:0] REG_CURSOR_DIR      = 5'h17;
	localparam logic [4:0] REG_LAYER_OVERLAY   = 5'h18;
	localparam logic [4:0] REG_PIXEL_SHIFT     = 5'h1b;
	localparam logic [4:0] REG_CURSOR_LOW      = 5'h1c;
	localparam logic [4:0] REG_CURSOR_HIGH     = 5'h1d;
	localparam int         REG_COUNT           = 32;
	localparam logic [7:0] REG_RESET           = 8'h00;
	// writable bits of the narrow registers
	localparam logic [7:0] MASK_SYSTEM_CONFIG  = 8'h2d;
	localparam logic [7:0] MASK_CHAR_WIDTH     = 8'h8f;
	localparam logic [7:0] MASK_NIBBLE         = 8'h0f;
	localparam logic [7:0] MASK_CURSOR_HEIGHT  = 8'h8f;
	localparam logic [7:0] MASK_PIXEL_SHIFT    = 8'h07;
	localparam logic [7:0] MASK_FULL           = 8'hff;
	// field positions
	localparam int BIT_GLYPH_SOURCE = 0;
	localparam int BIT_GLYPH_LINES  = 2;
	localparam int BIT_TWO_PANEL    = 3;
	localparam int BIT_TOP_LINE     = 5;
	localparam int BIT_AC_DRIVE     = 7;
	localparam int BIT_SHAPE_SEL    = 7;
	localparam int BIT_DISPLAY_EN   = 0;
	localparam int BIT_BLOCK1_TEXT  = 2;
	localparam int BIT_BLOCK3_TEXT  = 3;
	// command codes
	localparam logic [7:0] CMD_SYSTEM_SET    = 8'h40;
	localparam logic [7:0] CMD_MEMORY_STORE  = 8'h42;
	localparam logic [7:0] CMD_MEMORY_FETCH  = 8'h43;
	localparam logic [7:0] CMD_SCROLL        = 8'h44;
	localparam logic [7:0] CMD_CURSOR_LOAD   = 8'h46;
	localparam logic [7:0] CMD_CURSOR_FETCH  = 8'h47;
	localparam logic [5:0] CMD_CURSOR_STEP   = 6'h13;
	localparam logic [7:0] CMD_SCREEN_OFF    = 8'h58;
	localparam logic [7:0] CMD_SCREEN_ON     = 8'h59;
	localparam logic [7:0] CMD_PIXEL_SCROLL  = 8'h5a;
	localparam logic [7:0] CMD_LAYER_COMBINE = 8'h5b;
	localparam logic [7:0] CMD_CURSOR_SHAPE  = 8'h5d;
	localparam logic [3:0] CNT_SYSTEM_SET    = 4'h8;
	localparam logic [3:0] CNT_SCROLL        = 4'ha;
	localparam logic [3:0] CNT_ONE           = 4'h1;
	localparam logic [3:0] CNT_TWO           = 4'h2;
	// cursor step directions
	typedef enum logic [1:0] {
		LIC_DIR_RIGHT = 2'b00,
		LIC_DIR_LEFT  = 2'b01,
		LIC_DIR_UP    = 2'b10,
		LIC_DIR_DOWN  = 2'b11
	} lic_dir_t;
endpackage
`default_nettype wire

// ===== rtl/lic_cursor_step.sv
// next cursor address for one step in the selected direction
// assumes the line pitch is the virtual screen width
`default_nettype none
module lic_cursor_step (
	input  wire logic [15:0] addr_i,
	input  wire logic [1:0]  dir_i,
	input  wire logic [15:0] pitch_i,
	output logic      [15:0] next_o
);
	// wraps modulo 64k like the address counter itself
	always_comb begin
		case (lic_pkg::lic_dir_t'(dir_i))
			lic_pkg::LIC_DIR_RIGHT: next_o = addr_i + 16'h0001;
			lic_pkg::LIC_DIR_LEFT:  next_o = addr_i - 16'h0001;
			lic_pkg::LIC_DIR_UP:    next_o = addr_i - pitch_i;
			lic_pkg::LIC_DIR_DOWN:  next_o = addr_i + pitch_i;
			default:                next_o = addr_i;
		endcase
	end
endmodule
`default_nettype wire

// ===== rtl/lic_display_mem.sv
// display memory in flip-flops: one write port, host and scan reads
// assumes addresses are already cut to the memory width
`default_nettype none
module lic_display_mem #(
	parameter int AW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic [AW-1:0] haddr_i,
	output logic      [7:0]    hdata_o,
	input  wire logic [AW-1:0] saddr_i,
	output logic      [7:0]    sdata_o
);
	logic [7:0] mem_q [2**AW];
	logic [7:0] mem_d [2**AW];

	// next contents: one byte replaced on a write
	always_comb begin
		mem_d = mem_q;
		if (we_i) begin
			mem_d[waddr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_q[i] <= lic_pkg::REG_RESET;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	// read ports
	assign hdata_o = mem_q[haddr_i];
	assign sdata_o = mem_q[saddr_i];
endmodule
`default_nettype wire

// ===== test/lic_host_model.sv
// host processor model for the decoder's 8-bit parallel port
// assumes strobes one clock wide, changed only at rising clock edges
`default_nettype none
module lic_host_model (
	input  wire logic       clk_i,
	output logic            cs_n_o,
	output logic            sel_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] data_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		cs_n_o = 1'b1;
		sel_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		data_o = 8'h00;
	end

	// one write strobe: select high is a command, low a parameter
	task automatic wr(input logic s, input logic [7:0] d);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		sel_o <= s;
		wr_o <= 1'b1;
		rd_o <= 1'b0;
		data_o <= d;
	endtask

	// release the bus; stale data is inverted so nothing reuses it
	task automatic idle();
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		data_o <= ~data_o;
	endtask

	// one read strobe; answer is taken one cycle after the strobe
	task automatic rd(input logic s, output logic [7:0] d, output logic v);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		sel_o <= s;
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		cs_n_o <= 1'b1;
		#1;
		d = rdata_i;
		v = rvalid_i;
	endtask
endmodule
`default_nettype wire

// ===== test/lic_decoder_monitor.sv
// checker of host port timing and command effects of the decoder
// assumes it is bound to lic_decoder; a single clock domain
`default_nettype none
module lic_decoder_monitor (
	input wire logic        CLK_I,
	input wire logic        NRST_I,
	input wire logic        CS_N_I,
	input wire logic        CMD_DATA_SEL_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [7:0]  DATA_I,
	input wire logic [7:0]  DATA_O,
	input wire logic        DATA_OE_O,
	input wire logic        RD_VALID_O,
	input wire logic        DISPLAY_EN_O,
	input wire logic [1:0]  CURSOR_DIR_O,
	input wire logic [15:0] CURSOR_ADDR_O
);
	timeunit 1ns;
	timeprecision 1ps;

	logic cmd_t;
	logic par_t;
	logic rd_t;

	// accepted command, parameter and read strobes
	assign cmd_t = WR_I && !CS_N_I && CMD_DATA_SEL_I;
	assign par_t = WR_I && !CS_N_I && !CMD_DATA_SEL_I;
	assign rd_t = RD_I && !CS_N_I;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);

	AST_READ_ANSWER: assert property (rd_t |=> RD_VALID_O)
		else $error("read not answered in the next cycle");
	AST_NO_STRAY_VALID: assert property (RD_VALID_O |-> $past(rd_t))
		else $error("read valid without a read strobe");
	AST_OE_TRACKS_VALID: assert property (DATA_OE_O == RD_VALID_O)
		else $error("output enable differs from read valid");
	AST_DATA_HOLDS: assert property (!rd_t |=> $stable(DATA_O))
		else $error("read data changed without a read");
	AST_SCREEN_OFF: assert property (
		cmd_t && DATA_I == lic_pkg::CMD_SCREEN_OFF |=> !DISPLAY_EN_O)
		else $error("display still on after off command");
	AST_SCREEN_ON: assert property (
		cmd_t && DATA_I == lic_pkg::CMD_SCREEN_ON |=> DISPLAY_EN_O)
		else $error("display still off after on command");
	AST_EN_BY_CMD: assert property (!cmd_t |=> $stable(DISPLAY_EN_O))
		else $error("display enable moved without a command");
	AST_DIR_CODE: assert property (
		cmd_t && DATA_I[7:2] == lic_pkg::CMD_CURSOR_STEP
		|=> CURSOR_DIR_O == $past(DATA_I[1:0]))
		else $error("direction not taken from command code");
	AST_DIR_HOLDS: assert property (!cmd_t |=> $stable(CURSOR_DIR_O))
		else $error("direction moved without a command");
	AST_DESELECT: assert property (
		CS_N_I |=> $stable(CURSOR_ADDR_O) && !RD_VALID_O)
		else $error("deselected port changed state");
	AST_CURSOR_LOW: assert property (
		(cmd_t && DATA_I == lic_pkg::CMD_CURSOR_LOAD) ##1 par_t
		|=> CURSOR_ADDR_O[7:0] == $past(DATA_I))
		else $error("cursor low byte not loaded");
endmodule

bind lic_decoder lic_decoder_monitor u_mon (
	.CLK_I(CLK_I), .NRST_I(NRST_I), .CS_N_I(CS_N_I),
	.CMD_DATA_SEL_I(CMD_DATA_SEL_I), .WR_I(WR_I), .RD_I(RD_I),
	.DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
	.RD_VALID_O(RD_VALID_O), .DISPLAY_EN_O(DISPLAY_EN_O),
	.CURSOR_DIR_O(CURSOR_DIR_O), .CURSOR_ADDR_O(CURSOR_ADDR_O)
);
`default_nettype wire

// ===== test/lcd_indirect_command_decoder_bench.sv
// self-checking bench of the indirect command decoder
// assumes the host model drives the port and the checker is bound
`default_nettype none
module lcd_indirect_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, cs_n, sel, wr, rd, oe, rv, den, shp, t1, t3;
	logic        gs, gl, tp, tl, ac;
	logic [7:0]  wdat, rdat, sdat, lac, ltc, flc, b1l, b2l, d;
	logic [3:0]  cw, ch, crw, crh;
	logic [1:0]  fl, a1, a24, a3, dir, cmb;
	logic [2:0]  psh;
	logic [15:0] scan, vw, s1, s2, s3, s4, cur;
	logic        v;
	int          n_fail, samples_checked;

	lic_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sel_o(sel),
		.wr_o(wr), .rd_o(rd), .data_o(wdat), .rdata_i(rdat), .rvalid_i(rv));

	lic_decoder #(.MEM_AW(8)) uut (.CLK_I(clk), .NRST_I(nrst),
		.CS_N_I(cs_n), .CMD_DATA_SEL_I(sel), .WR_I(wr), .RD_I(rd),
		.DATA_I(wdat), .DATA_O(rdat), .DATA_OE_O(oe), .RD_VALID_O(rv),
		.SCAN_ADDR_I(scan), .SCAN_DATA_O(sdat), .GLYPH_SOURCE_SEL_O(gs),
		.GLYPH_LINES_SEL_O(gl), .TWO_PANEL_O(tp), .TOP_LINE_COMP_O(tl),
		.CELL_WIDTH_O(cw), .AC_DRIVE_SEL_O(ac), .CELL_HEIGHT_O(ch),
		.LINE_ADDR_COUNT_O(lac), .LINE_TOTAL_COUNT_O(ltc),
		.FRAME_LINE_COUNT_O(flc), .VIRTUAL_WIDTH_O(vw), .DISPLAY_EN_O(den),
		.CURSOR_FLASH_SEL_O(fl), .BLOCK1_ATTR_O(a1), .BLOCK2_4_ATTR_O(a24),
		.BLOCK3_ATTR_O(a3), .BLOCK1_START_O(s1), .BLOCK2_START_O(s2),
		.BLOCK3_START_O(s3), .BLOCK4_START_O(s4), .BLOCK1_LINES_O(b1l),
		.BLOCK2_LINES_O(b2l), .CURSOR_WIDTH_O(crw), .CURSOR_HEIGHT_O(crh),
		.CURSOR_SHAPE_SEL_O(shp), .CURSOR_DIR_O(dir), .COMBINE_METHOD_O(cmb),
		.BLOCK1_TEXT_SEL_O(t1), .BLOCK3_TEXT_SEL_O(t3),
		.PIXEL_SHIFT_O(psh), .CURSOR_ADDR_O(cur));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// one comparison, reported at once on mismatch
	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// command followed back to back by its parameters
	task automatic send(input logic [7:0] c, input logic [7:0] p[$]);
		host.wr(1'b1, c);
		foreach (p[i]) host.wr(1'b0, p[i]);
		host.idle();
		#1;
	endtask

	task automatic t_setup();
		send(8'h40, '{8'h38, 8'h87, 8'h07, 8'h3f, 8'h49, 8'h7f, 8'h80,
			8'h00, 8'hff});
		chk("glyph_src", 16'h0000, 16'(gs));
		chk("two_panel", 16'h0001, 16'(tp));
		chk("top_line", 16'h0001, 16'(tl));
		chk("cell_w", 16'h0007, 16'(cw));
		chk("ac_drive", 16'h0001, 16'(ac));
		chk("cell_h", 16'h0007, 16'(ch));
		chk("line_addr", 16'h003f, 16'(lac));
		chk("line_total", 16'h0049, 16'(ltc));
		chk("frame_lines", 16'h007f, 16'(flc));
		chk("vwidth", 16'h0080, vw);
		send(8'h40, '{8'h25});
		chk("glyph_src", 16'h0001, 16'(gs));
		chk("glyph_lines", 16'h0001, 16'(gl));
		chk("two_panel", 16'h0000, 16'(tp));
		chk("cell_w", 16'h0007, 16'(cw));
		$display("test setup done");
	endtask

	task automatic t_scroll();
		send(8'h44, '{8'h01, 8'h02, 8'h40, 8'h03, 8'h10, 8'h41, 8'h05,
			8'h04, 8'h06, 8'h30, 8'h0c});
		chk("block1", 16'h0201, s1);
		chk("block2", 16'h1003, s2);
		chk("block3", 16'h0405, s3);
		chk("block4", 16'h3006, s4);
		chk("lines1", 16'h0040, 16'(b1l));
		chk("lines2", 16'h0041, 16'(b2l));
		chk("surplus", 16'h0000, 16'(crw));
		$display("test scroll done");
	endtask

	task automatic t_attr();
		send(8'h5a, '{8'hff});
		chk("pix_shift", 16'h0007, 16'(psh));
		send(8'h5b, '{8'h0d});
		chk("combine", 16'h0001, 16'(cmb));
		chk("text1", 16'h0001, 16'(t1));
		chk("text3", 16'h0001, 16'(t3));
		send(8'h59, '{8'h56});
		chk("disp_en", 16'h0001, 16'(den));
		chk("flash", 16'h0002, 16'(fl));
		chk("attr", 16'h0015, {10'h000, a3, a24, a1});
		send(8'h58, '{8'h56});
		chk("disp_en", 16'h0000, 16'(den));
		send(8'h5d, '{8'h04, 8'h86});
		chk("cur_w", 16'h0004, 16'(crw));
		chk("cur_h", 16'h0006, 16'(crh));
		chk("cur_shape", 16'h0001, 16'(shp));
		send(8'h46, '{8'h01, 8'h10});
		chk("cursor", 16'h1001, cur);
		for (int i = 0; i < 4; i++) begin
			send(8'(8'h4c + i), '{8'hff});
			chk("dir", 16'(i), 16'(dir));
		end
		$display("test attributes done");
	endtask

	// layer fill, cursor stepping and read back; direction starts down
	task automatic t_mem();
		send(8'h46, '{8'h10, 8'h00});
		send(8'h42, '{8'h20});
		chk("cursor", 16'h0090, cur);
		send(8'h4c, '{8'haa});
		send(8'h42, '{8'h45, 8'h50});
		chk("cursor", 16'h0092, cur);
		@(posedge clk);
		scan <= 16'h0010;
		@(posedge clk);
		#1;
		chk("scan", 16'h0020, 16'(sdat));
		send(8'h46, '{8'h90, 8'h00});
		host.wr(1'b1, 8'h43);
		host.rd(1'b1, d, v);
		chk("mem0", 16'h0045, 16'(d));
		chk("valid", 16'h0001, 16'(v));
		chk("oe", 16'h0001, 16'(oe));
		host.rd(1'b1, d, v);
		chk("mem1", 16'h0050, 16'(d));
		host.rd(1'b0, d, v);
		chk("sel_low", 16'h0000, 16'(d));
		host.wr(1'b1, 8'h47);
		host.rd(1'b1, d, v);
		chk("cur_low", 16'h0092, 16'(d));
		host.rd(1'b1, d, v);
		chk("cur_high", 16'h0000, 16'(d));
		send(8'h4d, '{8'h00});
		send(8'h42, '{8'h11});
		chk("cur_left", 16'h0091, cur);
		send(8'h4e, '{8'h00});
		chk("dir_up", 16'h0002, 16'(dir));
		send(8'h42, '{8'h22});
		chk("cur_up", 16'h0011, cur);
		@(posedge clk);
		scan <= 16'h0091;
		@(posedge clk);
		#1;
		chk("scan_up", 16'h0022, 16'(sdat));
		$display("test memory done");
	endtask

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog against a hung run
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		print_verdict();
	end

	// reset then scenarios
	initial begin
		n_fail = 0;
		samples_checked = 0;
		nrst = 1'b0;
		scan = 16'h0000;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk("cursor_rst", 16'h0000, cur);
		chk("vwidth_rst", 16'h0000, vw);
		t_setup();
		t_scroll();
		t_attr();
		t_mem();
		print_verdict();
	end
endmodule
`default_nettype wire
